/* File: logic/pm_msi_defs.vh */
`ifndef PM_MSI_DEFS_VH
`define PM_MSI_DEFS_VH

// Register byte addresses
`define PMCS_OFF          8'hC4
`define MSI_HDR_OFF       8'hD0
`define EVT_STAT_OFF      8'hE0
`define EVT_MASK_OFF      8'hE4
`define LOCK_CTRL_OFF     8'hE8

// Power control/status fields
`define PS_LO             0
`define PS_HI             1
`define CTX_KEEP_BIT      3
`define WAKE_EN_BIT       8
`define WAKE_FLAG_BIT     15

// Power state codes
`define PS_D0             2'h0
`define PS_D1             2'h1
`define PS_D2             2'h2
`define PS_D3HOT          2'h3

// Interrupt capability header fields
`define CAP_CODE_LO       0
`define CAP_CODE_HI       7
`define NEXT_LINK_LO      8
`define NEXT_LINK_HI      15
`define MSG_EN_BIT        16
`define CAP_CODE_VAL      8'h05

// Reset values
`define PS_RST            2'h0
`define CTX_KEEP_RST      1'h1
`define WAKE_EN_RST       1'h0
`define NEXT_LINK_RST     8'h00
`define MSG_EN_RST        1'h0
`define LOCK_RST          1'h1

// Event status bits
`define EV_WAKE           0
`define EV_PS_CHANGE      1
`define EV_BAD_PS         2
`define EV_WIDTH          3

`endif

/* File: logic/pin_sync.v */
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
  input  wire clk,
  input  wire rst_b,
  input  wire d,
  output wire q
);

  reg meta_reg;
  reg sync_reg;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

`default_nettype wire

/* File: logic/pm_ctrl_status_msi_header.v */
`timescale 1ns/1ns
`default_nettype none
`include "pm_msi_defs.vh"

module pm_ctrl_status_msi_header (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        hot_rst_b,
  input  wire        is_upstream,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rdata,
  input  wire        port_wake_event,
  input  wire        fwd_wake_msg,
  output reg         wake_msg_req,
  output wire [1:0]  power_state,
  output wire        msg_int_enable,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins (wake, forward, hot reset) and reset-caught strap

  wire wake_pin_s;
  wire fwd_pin_s;
  wire hot_rst_s;
  reg  upstream_reg;

  pin_sync u_sync_wake (.clk(clk), .rst_b(rst_b), .d(port_wake_event), .q(wake_pin_s));
  pin_sync u_sync_fwd  (.clk(clk), .rst_b(rst_b), .d(fwd_wake_msg),    .q(fwd_pin_s));
  pin_sync u_sync_hrst (.clk(clk), .rst_b(rst_b), .d(~hot_rst_b),      .q(hot_rst_s));

  reg strap_done_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_reg <= 1'b0;
      upstream_reg   <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      upstream_reg   <= is_upstream;
    end
  end

  // Edge detect on the synchronised event, so a long pin level counts once
  reg wake_pin_d_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_pin_d_reg <= 1'b0;
    end else begin
      wake_pin_d_reg <= wake_pin_s;
    end
  end

  // Upstream port never originates a wake event
  wire own_wake = wake_pin_s & ~wake_pin_d_reg & ~upstream_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire wr_pmcs  = wr_en & (addr == `PMCS_OFF);
  wire wr_msi   = wr_en & (addr == `MSI_HDR_OFF);
  wire wr_stat  = wr_en & (addr == `EVT_STAT_OFF);
  wire wr_mask  = wr_en & (addr == `EVT_MASK_OFF);
  wire wr_lock  = wr_en & (addr == `LOCK_CTRL_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Non-sticky power control/status, header and lock fields, cleared by hot reset too

  reg  [1:0] ps_reg;
  reg        ctx_keep_reg;
  reg  [7:0] next_link_reg;
  reg        msg_en_reg;
  reg        lock_reg;

  wire [1:0] ps_wr = wdata[`PS_HI:`PS_LO];
  wire       ps_ok = (ps_wr == `PS_D0) | (ps_wr == `PS_D3HOT);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ps_reg        <= `PS_RST;
      ctx_keep_reg  <= `CTX_KEEP_RST;
      next_link_reg <= `NEXT_LINK_RST;
      msg_en_reg    <= `MSG_EN_RST;
      lock_reg      <= `LOCK_RST;
    end else if (hot_rst_s) begin
      ps_reg        <= `PS_RST;
      ctx_keep_reg  <= `CTX_KEEP_RST;
      next_link_reg <= `NEXT_LINK_RST;
      msg_en_reg    <= `MSG_EN_RST;
      lock_reg      <= `LOCK_RST;
    end else begin
      if (wr_pmcs && ps_ok) begin
        ps_reg <= ps_wr;
      end
      if (wr_pmcs && !lock_reg) begin
        ctx_keep_reg <= wdata[`CTX_KEEP_BIT];
      end
      if (wr_msi && !lock_reg) begin
        next_link_reg <= wdata[`NEXT_LINK_HI:`NEXT_LINK_LO];
      end
      if (wr_msi) begin
        msg_en_reg <= wdata[`MSG_EN_BIT];
      end
      if (wr_lock) begin
        lock_reg <= wdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky fields: only the power-on reset touches them

  reg wake_en_reg;
  reg wake_flag_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_en_reg   <= `WAKE_EN_RST;
      wake_flag_reg <= 1'b0;
    end else begin
      if (wr_pmcs) begin
        wake_en_reg <= wdata[`WAKE_EN_BIT];
      end
      // Set wins over a write-one clear; forwarded messages never set it
      if (own_wake) begin
        wake_flag_reg <= 1'b1;
      end else if (wr_pmcs && wdata[`WAKE_FLAG_BIT]) begin
        wake_flag_reg <= 1'b0;
      end
    end
  end

  // Message goes out for own events only while enabled; forwards pass through
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_msg_req <= 1'b0;
    end else begin
      wake_msg_req <= (own_wake & wake_en_reg) | fwd_pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  reg  [`EV_WIDTH-1:0] ev_stat_reg;
  reg  [`EV_WIDTH-1:0] ev_mask_reg;
  wire [`EV_WIDTH-1:0] ev_set;

  assign ev_set[`EV_WAKE]      = own_wake;
  assign ev_set[`EV_PS_CHANGE] = wr_pmcs & ps_ok & (ps_wr != ps_reg);
  assign ev_set[`EV_BAD_PS]    = wr_pmcs & ~ps_ok;

  genvar i;
  generate
    for (i = 0; i < `EV_WIDTH; i = i + 1) begin : g_ev
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ev_stat_reg[i] <= 1'b0;
        end else if (ev_set[i]) begin
          ev_stat_reg[i] <= 1'b1;
        end else if (wr_stat && wdata[i]) begin
          ev_stat_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_mask_reg <= {`EV_WIDTH{1'b0}};
    end else if (wr_mask) begin
      ev_mask_reg <= wdata[`EV_WIDTH-1:0];
    end
  end

  assign irq = |(ev_stat_reg & ev_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unused and reserved bits read zero

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (addr)
      `PMCS_OFF: begin
        rd_mux[`PS_HI:`PS_LO]  = ps_reg;
        rd_mux[`CTX_KEEP_BIT]  = ctx_keep_reg;
        rd_mux[`WAKE_EN_BIT]   = wake_en_reg;
        rd_mux[`WAKE_FLAG_BIT] = wake_flag_reg;
        // Data fields and bus power bits stay zero
      end
      `MSI_HDR_OFF: begin
        rd_mux[`CAP_CODE_HI:`CAP_CODE_LO]   = `CAP_CODE_VAL;
        rd_mux[`NEXT_LINK_HI:`NEXT_LINK_LO] = next_link_reg;
        rd_mux[`MSG_EN_BIT]                 = msg_en_reg;
      end
      `EVT_STAT_OFF: begin
        rd_mux[`EV_WIDTH-1:0] = ev_stat_reg;
      end
      `EVT_MASK_OFF: begin
        rd_mux[`EV_WIDTH-1:0] = ev_mask_reg;
      end
      `LOCK_CTRL_OFF: begin
        rd_mux[0] = lock_reg;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h00000000;
    end
  end

  assign power_state    = ps_reg;
  assign msg_int_enable = msg_en_reg;

endmodule

`default_nettype wire

/* File: verification/pm_msi_props.sv */
`timescale 1ns/1ns
`default_nettype none
module pm_msi_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hot_rst_b,
  input wire logic        is_upstream,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  power_state,
  input wire logic        msg_int_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pm_fixed_a: assert property (rd_en && addr == 8'hC4 |=> (rdata & 32'hFFFF_7EF4) == 32'h0)
    else $error("fixed power bits not zero");
  cap_code_a: assert property (rd_en && addr == 8'hD0 |=> rdata[7:0] == 8'h05)
    else $error("capability code wrong");
  ps_read_a: assert property (rd_en && addr == 8'hC4 |=> rdata[1:0] == $past(power_state))
    else $error("power state read mismatch");
  ps_keep_a: assert property (wr_en && addr == 8'hC4 && wdata[0] != wdata[1]
    && hot_rst_b && $past(hot_rst_b, 3) |=> $stable(power_state))
    else $error("reserved state accepted");
  ps_take_a: assert property (wr_en && addr == 8'hC4 && wdata[0] == wdata[1]
    && hot_rst_b && $past(hot_rst_b, 3) |=> power_state == $past(wdata[1:0]))
    else $error("power state not taken");
  msg_set_a: assert property (wr_en && addr == 8'hD0 && hot_rst_b && $past(hot_rst_b, 3)
    |=> msg_int_enable == $past(wdata[16]))
    else $error("message enable not taken");
  msg_hold_a: assert property (!(wr_en && addr == 8'hD0) && hot_rst_b && $past(hot_rst_b, 3)
    |=> $stable(msg_int_enable))
    else $error("message enable changed");
  up_flag_a: assert property (is_upstream && rd_en && addr == 8'hC4 |=> !rdata[15])
    else $error("upstream wake flag set");
  cover property (wr_en && addr == 8'hC4 && wdata[1:0] == 2'h1);
  cover property (rd_en && addr == 8'hD0);
  cover property (!hot_rst_b);
endmodule
bind pm_ctrl_status_msi_header pm_msi_props chk_u (.clk(clk), .rst_b(rst_b),
  .hot_rst_b(hot_rst_b), .is_upstream(is_upstream), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .power_state(power_state),
  .msg_int_enable(msg_int_enable));
`default_nettype wire

/* File: verification/cfg_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  output var  logic [7:0]  addr = 8'h00,
  output var  logic [31:0] wdata = 32'h0,
  output var  logic        wr_en = 1'b0,
  output var  logic        rd_en = 1'b0
);
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~v;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hot_rst_b = 1'b1;
  logic        is_upstream = 1'b0;
  logic        wake_pin = 1'b0;
  logic        fwd = 1'b0;
  logic [31:0] d;
  wire  [7:0]  addr;
  wire  [31:0] wdata, rdata;
  wire  [1:0]  power_state;
  wire         wr_en, rd_en, wake_msg_req, msg_int_enable, irq;
  int          num_errors = 0;
  int          n_checks = 0;
  always #4 clk = ~clk;
  cfg_host_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en));
  pm_ctrl_status_msi_header dut_u (.clk(clk), .rst_b(rst_b), .hot_rst_b(hot_rst_b),
    .is_upstream(is_upstream), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .port_wake_event(wake_pin), .fwd_wake_msg(fwd),
    .wake_msg_req(wake_msg_req), .power_state(power_state),
    .msg_int_enable(msg_int_enable), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wait_req;
    int i;
    for (i = 0; i < 20 && wake_msg_req !== 1'b1; i++) @(negedge clk);
    if (i == 20) begin
      num_errors++;
      summarize;
    end
  endtask
  task do_reset(input logic up);
    rst_b <= 1'b0;
    is_upstream <= up;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task t_defaults;
    host_u.rd(8'hC4, d); chk("pmcs", d, 32'h0000_0008);
    host_u.rd(8'hD0, d); chk("msi_capability_header", d, 32'h0000_0005);
    host_u.rd(8'h10, d); chk("unmapped", d, 32'h0);
    host_u.wr(8'hC4, 32'hFFFF_FFFF);
    host_u.rd(8'hC4, d); chk("pmcs ones", d, 32'h0000_010B);
  endtask
  task t_power_state_field;
    for (int c = 1; c < 3; c++) begin
      host_u.wr(8'hC4, 32'h0000_0100 | c);
      host_u.rd(8'hC4, d); chk("ps reserved", d, 32'h0000_010B);
    end
    host_u.wr(8'hE8, 32'h0);
    host_u.wr(8'hC4, 32'h0000_0100);
    host_u.rd(8'hC4, d); chk("ps d0 ctx", d, 32'h0000_0100);
    host_u.wr(8'hD0, 32'h0001_4000);
    host_u.rd(8'hD0, d); chk("msi_capability_header w", d, 32'h0001_4005);
  endtask
  task t_wake;
    wake_pin <= 1'b1;
    wait_req;
    wake_pin <= 1'b0;
    host_u.wr(8'hC4, 32'h0000_0100);
    host_u.rd(8'hC4, d); chk("flag kept", d, 32'h0000_8100);
    host_u.wr(8'hE4, 32'h7);
    host_u.rd(8'hE4, d); chk("mask", d, 32'h0000_0007);
    chk("irq on", irq, 1'b1);
    host_u.wr(8'hC4, 32'h0000_8100);
    host_u.wr(8'hE0, 32'h7);
    host_u.rd(8'hC4, d); chk("flag clr", d, 32'h0000_0100);
    chk("irq off", irq, 1'b0);
    fwd <= 1'b1;
    wait_req;
    fwd <= 1'b0;
    host_u.rd(8'hC4, d); chk("fwd flag", d, 32'h0000_0100);
  endtask
  task t_hot;
    host_u.wr(8'hC4, 32'h0000_0103);
    hot_rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    hot_rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    host_u.rd(8'hC4, d); chk("hot rst", d, 32'h0000_0108);
  endtask
  task t_upstream;
    do_reset(1'b1);
    host_u.wr(8'hC4, 32'h0000_0100);
    wake_pin <= 1'b1;
    repeat (8) @(posedge clk);
    wake_pin <= 1'b0;
    host_u.rd(8'hC4, d); chk("up flag", d, 32'h0000_0108);
  endtask
  initial begin
    @(posedge clk);
    do_reset(1'b0);
    t_defaults;
    t_power_state_field;
    t_wake;
    t_hot;
    t_upstream;
    summarize;
  end
endmodule
`default_nettype wire
